// ### rar_pkg.sv
// constants for the right adc input routing register pair
// Functional notes
// - bit 7 picks single-ended (0) or fully differential (1) input mode
// - level field bits 6..3 attenuate 1.5 dB per code, 0 dB to 12 dB
// - defined level codes connect the input; code 1111 (reset) disconnects it
// - first register bit 2 powers right adc channel up; reset is down
// - stepping field: 00 every sample, 01 every two samples, 1x disabled
// - second register bit 2 enables weak common-mode bias of unselected inputs
// - second register bits 1..0 read zero, are read-only; host writes zeros
`default_nettype none
package rar_pkg;
  localparam logic [7:0] RAR_LINE_ONE_OFFSET = 8'h16;
  localparam logic [7:0] RAR_LINE_TWO_OFFSET = 8'h17;
  localparam int         RAR_MODE_BIT        = 7;
  localparam int         RAR_LEVEL_MSB       = 6;
  localparam int         RAR_LEVEL_LSB       = 3;
  localparam int         RAR_POWER_BIT       = 2;
  localparam int         RAR_BIAS_BIT        = 2;
  localparam int         RAR_STEP_MSB        = 1;
  localparam int         RAR_STEP_LSB        = 0;
  localparam logic [7:0] RAR_LINE_ONE_RESET  = 8'h78;
  localparam logic [7:0] RAR_LINE_TWO_RESET  = 8'h78;
  localparam logic [7:0] RAR_LINE_TWO_WMASK  = 8'hFC;
  localparam logic [3:0] RAR_LEVEL_OFF       = 4'hF;
  localparam logic [3:0] RAR_LEVEL_MAX       = 4'h8;
  localparam logic [1:0] RAR_STEP_EVERY_FS   = 2'h0;
  localparam logic [1:0] RAR_STEP_EVERY_2FS  = 2'h1;
  localparam logic [1:0] RAR_STEP_TICKS_1    = 2'h0;
  localparam logic [1:0] RAR_STEP_TICKS_2    = 2'h1;
endpackage
`default_nettype wire

// ### rar_level_stepper.sv
// one input's applied attenuation level with soft stepping toward the target
`default_nettype none
module rar_level_stepper
  import rar_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] target,
  input  wire logic       step_now,
  input  wire logic       step_on,
  output logic      [3:0] level
);
  typedef struct packed {
    logic [3:0] level;
  } rar_step_state_t;

  rar_step_state_t state_reg;
  rar_step_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (!step_on || target == RAR_LEVEL_OFF || state_reg.level == RAR_LEVEL_OFF ||
        target > RAR_LEVEL_MAX) begin
      state_next.level = target;
    end else if (step_now && state_reg.level < target) begin
      state_next.level = state_reg.level + 4'h1;
    end else if (step_now && state_reg.level > target) begin
      state_next.level = state_reg.level - 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.level <= RAR_LEVEL_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.level;
endmodule
`default_nettype wire

// ### rar_routing_regs.sv
// right adc input routing register pair and its analog control outputs
`default_nettype none
module rar_routing_regs
  import rar_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic       fs_tick,
  output logic      [7:0] reg_rdata,
  output logic            first_right_line_input_diff,
  output logic            first_right_line_input_connect,
  output logic      [3:0] first_right_line_input_atten,
  output logic            second_right_line_input_diff,
  output logic            second_right_line_input_connect,
  output logic      [3:0] second_right_line_input_atten,
  output logic            right_adc_power_up,
  output logic            right_unselected_bias_en
);
  // timing seen from the register side:
  //   write taken at edge n, register holds the new value after n
  //   mode, power and bias outputs change at edge n+1
  //   applied level moves at n+1 (or per step), connect and level outputs at n+2
  //   read data is captured at the strobe edge and held until the next read
  // the applied level of each input lives in its own stepper
  typedef struct packed {
    logic [7:0] line_one;
    logic [7:0] line_two;
    logic [7:0] rdata;
    logic       fs_phase;
    logic       step_now;
    logic [1:0] diff;
    logic [1:0] connect;
    logic [7:0] atten;
    logic       power;
    logic       bias;
  } rar_regs_state_t;

  rar_regs_state_t state_reg;
  rar_regs_state_t state_next;
  logic [1:0]      rst_sync_reg;
  logic            rst_n;
  logic [7:0]      target_pair;
  logic [7:0]      level_pair;
  logic            step_on;
  logic            wr_one;
  logic            wr_two;
  logic [7:0]      rd_value;
  logic [1:0]      step_field;

  // an input reaches the mix only for a defined gain code
  function automatic logic level_connects(input logic [3:0] code);
    level_connects = (code <= RAR_LEVEL_MAX);
  endfunction

  // address match for one register of the pair
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction

  // value returned on a read; other addresses read as zero
  function automatic logic [7:0] read_value(input logic [7:0] addr,
                                            input logic [7:0] one,
                                            input logic [7:0] two);
    case (addr)
      RAR_LINE_ONE_OFFSET: read_value = one;
      RAR_LINE_TWO_OFFSET: read_value = two & RAR_LINE_TWO_WMASK;
      default:             read_value = 8'h00;
    endcase
  endfunction

  // step pulse for one sample tick under the selected pacing
  function automatic logic step_due(input logic [1:0] field,
                                    input logic       phase);
    case (field)
      RAR_STEP_EVERY_FS:  step_due = 1'b1;
      RAR_STEP_EVERY_2FS: step_due = phase;
      default:            step_due = 1'b0;
    endcase
  endfunction

  // phase of the every-other-sample pacing after one tick
  function automatic logic next_phase(input logic [1:0] field,
                                      input logic       phase);
    if (field == RAR_STEP_EVERY_2FS) begin
      next_phase = !phase;
    end else begin
      next_phase = 1'b0;
    end
  endfunction

  // reset release passes two flops so the pair leaves reset on a clock edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg[0] <= 1'b1;
      rst_sync_reg[1] <= rst_sync_reg[0];
    end
  end
  assign rst_n = rst_sync_reg[1];

  // decoded strobes and fields shared by the data path
  assign wr_one      = reg_wr && reg_hit(reg_addr, RAR_LINE_ONE_OFFSET);
  assign wr_two      = reg_wr && reg_hit(reg_addr, RAR_LINE_TWO_OFFSET);
  assign rd_value    = read_value(reg_addr, state_reg.line_one, state_reg.line_two);
  assign step_field  = state_reg.line_one[RAR_STEP_MSB:RAR_STEP_LSB];
  assign step_on = !state_reg.line_one[RAR_STEP_MSB];
  assign target_pair = {state_reg.line_two[RAR_LEVEL_MSB:RAR_LEVEL_LSB],
                        state_reg.line_one[RAR_LEVEL_MSB:RAR_LEVEL_LSB]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_step
      rar_level_stepper u_step (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .target   (target_pair[gi*4 +: 4]),
        .step_now (state_reg.step_now),
        .step_on  (step_on),
        .level    (level_pair[gi*4 +: 4])
      );
    end
  endgenerate

  always_comb begin
    state_next = state_reg;

    // writes land at the edge that takes them
    if (wr_one) begin
      state_next.line_one = reg_wdata;
    end
    if (wr_two) begin
      state_next.line_two = reg_wdata & RAR_LINE_TWO_WMASK;
    end

    // read data is captured once and held until the next read
    if (reg_rd) begin
      state_next.rdata = rd_value;
    end

    // pace one gain step per sample or per two samples
    state_next.step_now = 1'b0;
    if (fs_tick) begin
      state_next.step_now = step_due(step_field, state_reg.fs_phase);
      state_next.fs_phase = next_phase(step_field, state_reg.fs_phase);
    end

    // mode, power and bias follow the registers one edge later; connect and level follow the steppers one edge later
    state_next.diff = {state_reg.line_two[RAR_MODE_BIT],
                       state_reg.line_one[RAR_MODE_BIT]};
    state_next.connect = {level_connects(level_pair[7:4]),
                          level_connects(level_pair[3:0])};
    state_next.atten = level_pair;
    state_next.power = state_reg.line_one[RAR_POWER_BIT];
    state_next.bias = state_reg.line_two[RAR_BIAS_BIT];
  end

  // all state of the pair except the stepper levels; reset comes from the synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.line_one <= RAR_LINE_ONE_RESET;
      state_reg.line_two <= RAR_LINE_TWO_RESET;
      state_reg.rdata    <= 8'h00;
      state_reg.fs_phase <= 1'b0;
      state_reg.step_now <= 1'b0;
      state_reg.diff     <= 2'h0;
      state_reg.connect  <= 2'h0;
      state_reg.atten    <= {RAR_LEVEL_OFF, RAR_LEVEL_OFF};
      state_reg.power    <= 1'b0;
      state_reg.bias     <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output is a state flop
  assign reg_rdata                       = state_reg.rdata;
  assign first_right_line_input_diff     = state_reg.diff[0];
  assign second_right_line_input_diff    = state_reg.diff[1];
  assign first_right_line_input_connect  = state_reg.connect[0];
  assign second_right_line_input_connect = state_reg.connect[1];
  assign first_right_line_input_atten    = state_reg.atten[3:0];
  assign second_right_line_input_atten   = state_reg.atten[7:4];
  assign right_adc_power_up              = state_reg.power;
  assign right_unselected_bias_en        = state_reg.bias;
endmodule
`default_nettype wire

// ### rar_routing_regs_monitor.sv
// assertion checker for the right adc routing register pair
`default_nettype none
module rar_routing_regs_monitor
  import rar_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       first_right_line_input_diff,
  input wire logic       first_right_line_input_connect,
  input wire logic [3:0] first_right_line_input_atten,
  input wire logic       second_right_line_input_diff,
  input wire logic       second_right_line_input_connect,
  input wire logic       right_adc_power_up,
  input wire logic       right_unselected_bias_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // a write followed by a quiet cycle on the same register
  sequence s_one;
    reg_wr && reg_addr == 8'h16 ##1 !(reg_wr && reg_addr == 8'h16);
  endsequence
  sequence s_two;
    reg_wr && reg_addr == 8'h17 ##1 !(reg_wr && reg_addr == 8'h17);
  endsequence
  a_one_mode: assert property (s_one |=>
    first_right_line_input_diff == $past(reg_wdata[7], 2)) else $error("mode one wrong");
  a_two_mode: assert property (s_two |=>
    second_right_line_input_diff == $past(reg_wdata[7], 2)) else $error("mode two wrong");
  a_one_link: assert property (s_one |=> ##1
    first_right_line_input_connect == ($past(reg_wdata[6:3], 3) <= 4'h8))
    else $error("connect one wrong");
  a_two_link: assert property (s_two |=> ##1
    second_right_line_input_connect == ($past(reg_wdata[6:3], 3) <= 4'h8))
    else $error("connect two wrong");
  a_power_ctrl: assert property (s_one |=>
    right_adc_power_up == $past(reg_wdata[2], 2)) else $error("power wrong");
  a_bias_ctrl: assert property (s_two |=>
    right_unselected_bias_en == $past(reg_wdata[2], 2)) else $error("bias wrong");
  a_low_zero: assert property (reg_rd && reg_addr == 8'h17 |=>
    reg_rdata[1:0] == 2'h0) else $error("low bits not zero");
  a_reset_off: assert property ($rose(resetn) |->
    first_right_line_input_atten == 4'hF && !first_right_line_input_connect)
    else $error("reset level wrong");
endmodule

bind rar_routing_regs rar_routing_regs_monitor rar_routing_regs_monitor_i (
  .core_clk                        (core_clk),
  .resetn                          (resetn),
  .reg_addr                        (reg_addr),
  .reg_wdata                       (reg_wdata),
  .reg_wr                          (reg_wr),
  .reg_rd                          (reg_rd),
  .reg_rdata                       (reg_rdata),
  .first_right_line_input_diff     (first_right_line_input_diff),
  .first_right_line_input_connect  (first_right_line_input_connect),
  .first_right_line_input_atten    (first_right_line_input_atten),
  .second_right_line_input_diff    (second_right_line_input_diff),
  .second_right_line_input_connect (second_right_line_input_connect),
  .right_adc_power_up              (right_adc_power_up),
  .right_unselected_bias_en        (right_unselected_bias_en)
);
`default_nettype wire

// ### tb_rar_routing_regs.sv
// self-checking bench for the right adc routing register pair
`default_nettype none
module tb_rar_routing_regs;
  import rar_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fs_tick = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       first_right_line_input_diff, first_right_line_input_connect;
  logic       second_right_line_input_diff, second_right_line_input_connect;
  logic       right_adc_power_up, right_unselected_bias_en;
  logic [3:0] first_right_line_input_atten, second_right_line_input_atten;
  int         errors = 0, checks = 0;
  wire  [7:0] o1 = {first_right_line_input_diff, first_right_line_input_connect,
                    right_adc_power_up, 1'b0, first_right_line_input_atten};
  wire  [7:0] o2 = {second_right_line_input_diff, second_right_line_input_connect,
                    right_unselected_bias_en, 1'b0, second_right_line_input_atten};

  rar_routing_regs rar_routing_regs_i (
    .core_clk                        (core_clk),
    .resetn                          (resetn),
    .reg_addr                        (reg_addr),
    .reg_wdata                       (reg_wdata),
    .reg_wr                          (reg_wr),
    .reg_rd                          (reg_rd),
    .fs_tick                         (fs_tick),
    .reg_rdata                       (reg_rdata),
    .first_right_line_input_diff     (first_right_line_input_diff),
    .first_right_line_input_connect  (first_right_line_input_connect),
    .first_right_line_input_atten    (first_right_line_input_atten),
    .second_right_line_input_diff    (second_right_line_input_diff),
    .second_right_line_input_connect (second_right_line_input_connect),
    .second_right_line_input_atten   (second_right_line_input_atten),
    .right_adc_power_up              (right_adc_power_up),
    .right_unselected_bias_en        (right_unselected_bias_en)
  );

  always #2 core_clk = ~core_clk;

  task automatic chk(input string n, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk) #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk) #1;
    reg_wr = 1'b0;
    idle(3);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk) #1;
    reg_rd = 1'b0;
    chk("rdata", reg_rdata, exp);
  endtask
  // n sample ticks, then the applied level of input one
  task automatic tick(input int n, input logic [7:0] exp);
    repeat (n) begin
      fs_tick = 1'b1;
      @(posedge core_clk) #1;
      fs_tick = 1'b0;
      idle(4);
    end
    chk("atten1", {4'h0, first_right_line_input_atten}, exp);
  endtask
  task automatic stop_test;
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    idle(2);
    resetn = 1'b1;
    idle(3);
    chk("out1", o1, 8'h0F);
    chk("out2", o2, 8'h0F);
    rd(8'h16, 8'h78);
    rd(8'h17, 8'h78);
    wr(8'h17, 8'hFC);
    rd(8'h17, 8'hFC);
    chk("out2", o2, 8'hAF);
    wr(8'h17, 8'h04);
    chk("out2", o2, 8'h60);
    wr(8'h16, 8'h86);
    chk("out1", o1, 8'hE0);
    wr(8'h16, 8'h9C);
    chk("out1", o1, 8'hE0);
    for (int i = 1; i < 4; i++) tick(1, 8'(i));
    wr(8'h16, 8'hAD);
    tick(2, 8'h04);
    tick(2, 8'h05);
    wr(8'h16, 8'hC7);
    chk("out1", o1, 8'hE8);
    wr(8'h16, 8'h87);
    chk("out1", o1, 8'hE0);
    wr(8'h16, 8'h7C);
    chk("out1", o1, 8'h2F);
    wr(8'h18, 8'hAA);
    rd(8'h18, 8'h00);
    rd(8'h16, 8'h7C);
    stop_test();
  end
endmodule
`default_nettype wire
